// ===== testbench/csf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module csf_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        main_txd,
	input wire logic        rdr_txd,
	input wire logic        reader_fitted
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// unaligned or past the last word earns an error answer
	wire logic bad_w = awaddr[1:0] != 2'h0 || awaddr > 8'h18;
	wire logic bad_r = araddr[1:0] != 2'h0 || araddr > 8'h18;
	// both write halves meet in one edge when the slave is idle
	sequence wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_take;
		arvalid && arready;
	endsequence
	// write answers two edges after the take, read answers one edge after
	a_wr_answer: assert property (wr_take |-> ##2 bvalid && bresp == ($past(bad_w, 2) ? 2'h2 : 2'h0)) else $error("write answer");
	a_rd_answer: assert property (rd_take |=> rvalid && rresp == ($past(bad_r) ? 2'h2 : 2'h0)) else $error("read answer");
	a_rd_zero: assert property (rd_take ##0 bad_r |=> rdata == 32'h0) else $error("error read data");
	// a pending answer blocks new requests
	a_b_block: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
	a_r_block: assert property (rvalid |-> !arready) else $error("read taken early");
	a_b_release: assert property (bvalid && bready |=> !bvalid) else $error("write answer lingers");
	a_r_release: assert property (rvalid && rready |=> !rvalid) else $error("read answer lingers");
	// strap lag is two edges, so four cycles unfitted is safely settled
	a_rdr_quiet: assert property ((!reader_fitted) [*4] |-> rdr_txd) else $error("reader line moved");
	a_idle_high: assert property ($rose(aresetn) |-> main_txd && rdr_txd) else $error("line not idle");
endmodule
bind configurable_serial_framing csf_checker chk_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready), .main_txd(main_txd), .rdr_txd(rdr_txd), .reader_fitted(reader_fitted));
`default_nettype wire

// ===== testbench/ser_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ser_partner (
	input  wire logic aclk,
	input  wire logic line_in,
	output var  logic line_out
);
	// mark level between frames
	initial line_out = 1'b1;
	// shift a prepared frame out, bit 0 first
	task automatic send(input logic [11:0] f, input int n, input int bp);
		for (int i = 0; i < n; i++)
		begin
			line_out <= f[i];
			repeat (bp) @(posedge aclk);
		end
		line_out <= 1'b1;
	endtask
	// mid-bit sampling; stops at the last bit so its tail can still be probed
	task automatic grab(output logic [11:0] f, input int n, input int bp);
		f = '1;
		for (int k = 0; k < 30000 && line_in !== 1'b0; k++) @(posedge aclk);
		repeat (bp / 2) @(posedge aclk);
		for (int i = 0; i < n; i++)
		begin
			f[i] = line_in;
			if (i < n - 1) repeat (bp) @(posedge aclk);
		end
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, reader_fitted;
	logic        awready, wready, bvalid, arready, rvalid, main_txd, main_rxd, rdr_txd, rdr_rxd;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, q;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [11:0] f;
	int          n_errors, cmp_count, cyc;
	int          bpt[5] = '{800, 400, 200, 100, 33};
	// small clock figure keeps bit periods short
	configurable_serial_framing #(.CLK_HZ(1920000)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .main_txd(main_txd), .main_rxd(main_rxd),
		.rdr_txd(rdr_txd), .rdr_rxd(rdr_rxd), .reader_fitted(reader_fitted));
	ser_partner p_main (.aclk(aclk), .line_in(main_txd), .line_out(main_rxd));
	ser_partner p_rdr (.aclk(aclk), .line_in(rdr_txd), .line_out(rdr_rxd));
	// 200 MHz
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
			n_errors++;
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// readiness judged at the falling edge, acted on just after the rising one
	task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
		bit ta, tw, tr;
		@(posedge aclk);
		tr = 1'b0;
		if (wr) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		else {araddr, arvalid, rready} <= {a, 2'h3};
		while (!tr)
		begin
			@(negedge aclk);
			ta = wr ? awready : arready;
			tw = wready && wr;
			tr = wr ? bvalid : rvalid;
			{q, r} = {rdata, wr ? bresp : rresp};
			@(posedge aclk);
			if (ta && wr) awvalid <= 1'b0;
			if (ta && !wr) arvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) {bready, rready} <= 2'h0;
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 32'h0);
		check(q, e);
	endtask
	task automatic idle_wait(input int b);
		q = '1;
		for (int k = 0; k < 3000 && q[b] !== 1'b0; k++) bus(0, 8'h18, 32'h0);
	endtask
	// expected frame: start, data lsb first, parity, then high stops
	function automatic logic [11:0] fb(input logic [7:0] d, input int nd, input int par);
		logic [11:0] x;
		logic p;
		x = 12'hffe;
		p = (par == 2);
		for (int i = 0; i < nd; i++)
		begin
			x[i + 1] = d[i];
			p ^= d[i];
		end
		if (par != 0) x[nd + 1] = p;
		return x;
	endfunction
	task automatic t_regs();
		rdc(8'h00, 32'h22);
		rdc(8'h04, 32'h21);
		bus(0, 8'h1c, 32'h0);
		check(q, 32'h0);
		check(r, 2'h2);
		bus(1, 8'h02, 32'h0);
		check(r, 2'h2);
	endtask
	// every length, stop count and parity at 57600; busy probed mid last bit
	task automatic t_frames();
		int nd, ns, pe;
		logic [7:0] d;
		for (int fc = 0; fc < 4; fc++)
			for (int p = 0; p < 3; p++)
			begin
				nd = fc[1] ? 8 : 7;
				ns = fc[0] ? 2 : 1;
				pe = (fc == 3) ? 0 : p;
				d = 8'ha5 ^ 8'(fc * 3 + p);
				bus(1, 8'h00, 32'(32'h40 | (p << 2) | fc));
				bus(1, 8'h08, {24'h0, d});
				p_main.grab(f, 1 + nd + (pe != 0) + ns, 33);
				check(f, fb(d, nd, pe));
				bus(0, 8'h18, 32'h0);
				check(q[0], 1'b1);
				idle_wait(0);
			end
	endtask
	// a lone high data bit measures one period exactly
	task automatic t_rates();
		int c;
		for (int i = 0; i < 5; i++)
		begin
			bus(1, 8'h00, 32'(i << 4));
			bus(1, 8'h08, 32'h2);
			c = 0;
			@(negedge aclk);
			for (int k = 0; k < 2000 && main_txd !== 1'b1; k++) @(negedge aclk);
			for (; c < 2000 && main_txd === 1'b1; c++) @(negedge aclk);
			check(c, bpt[i]);
			idle_wait(0);
		end
	endtask
	task automatic t_rx();
		bus(1, 8'h00, 32'h46);
		p_main.send(fb(8'h96, 8, 1), 11, 33);
		rdc(8'h10, 32'h196);
		p_main.send(fb(8'h96, 8, 1) ^ 12'h200, 11, 33);
		rdc(8'h10, 32'h396);
		p_main.send(fb(8'h96, 8, 1) ^ 12'h400, 11, 33);
		rdc(8'h10, 32'h596);
	endtask
	task automatic t_reader();
		bus(1, 8'h04, 32'h100);
		rdc(8'h04, 32'h128);
		bus(1, 8'h04, 32'h103);
		rdc(8'h04, 32'h128);
		bus(1, 8'h0c, 32'h35);
		p_rdr.grab(f, 10, 200);
		check(f, fb(8'h35, 7, 2));
		idle_wait(1);
		bus(1, 8'h04, 32'h0);
		rdc(8'h04, 32'h21);
		p_rdr.send(fb(8'h41, 7, 0), 10, 200);
		rdc(8'h14, 32'h141);
	endtask
	// strap only changes under reset
	task automatic t_unfit();
		int lows;
		{reader_fitted, aresetn} <= 2'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		bus(1, 8'h04, 32'h100);
		rdc(8'h04, 32'h21);
		bus(1, 8'h0c, 32'h0);
		lows = 0;
		for (int k = 0; k < 300; k++) @(negedge aclk) lows += (rdr_txd !== 1'b1);
		check(lows, 0);
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{wstrb, reader_fitted} = 5'h1f;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_frames();
		t_rates();
		t_rx();
		t_reader();
		t_unfit();
		tally_and_finish();
	end
	// hang guard
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
endmodule
`default_nettype wire

// ===== verilog/configurable_serial_framing.v
`include "configurable_serial_framing_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module configurable_serial_framing #(
	parameter CLK_HZ = `CLK_HZ_DEF
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	output wire        main_txd,
	input  wire        main_rxd,
	output wire        rdr_txd,
	input  wire        rdr_rxd,
	input  wire        reader_fitted
);

	// bit periods in clock cycles, rounded down; full quotient cut to counter width on purpose
	localparam [31:0] Q_2400    = CLK_HZ / `BAUD_2400;
	localparam [31:0] Q_4800    = CLK_HZ / `BAUD_4800;
	localparam [31:0] Q_9600    = CLK_HZ / `BAUD_9600;
	localparam [31:0] Q_19200   = CLK_HZ / `BAUD_19200;
	localparam [31:0] Q_57600   = CLK_HZ / `BAUD_57600;
	localparam [16:0] DIV_2400  = Q_2400[16:0];
	localparam [16:0] DIV_4800  = Q_4800[16:0];
	localparam [16:0] DIV_9600  = Q_9600[16:0];
	localparam [16:0] DIV_19200 = Q_19200[16:0];
	localparam [16:0] DIV_57600 = Q_57600[16:0];
	localparam [1:0]  RX_IDLE   = 2'h0;
	localparam [1:0]  RX_START  = 2'h1;
	localparam [1:0]  RX_DATA   = 2'h2;
	localparam [1:0]  RX_DONE   = 2'h3;

	reg              fit_s1_q;
	reg              fit_s2_q;
	reg  [6:0]       main_cfg_q;
	reg  [6:0]       rdr_cfg_q;
	reg  [1:0]       rdr_type_q;
	reg              aw_got_q;
	reg              w_got_q;
	reg  [7:0]       aw_addr_q;
	reg  [31:0]      w_data_q;
	reg  [3:0]       w_strb_q;
	reg  [1:0]       rxv_q;
	reg  [21:0]      rx_word_q;
	wire [13:0]      cfg_eff;
	wire [1:0]       port_en;
	wire [1:0]       rx_in;
	wire [1:0]       txd;
	wire [1:0]       tx_go;
	wire [1:0]       tx_busy;
	wire [1:0]       rx_done;
	wire [21:0]      rx_res;
	wire [1:0]       rd_clear;
	wire             wr_fire;
	wire             rd_fire;
	wire             rdr_locked;
	wire [1:0]       new_type;

	// strap passes two flops before use
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fit_s1_q <= 1'b0;
			fit_s2_q <= 1'b0;
		end
		else
		begin
			fit_s1_q <= reader_fitted;
			fit_s2_q <= fit_s1_q;
		end
	end

	// reader type only matters when the reader port is fitted
	assign rdr_locked   = fit_s2_q && (rdr_type_q == `RT_DECODE);
	assign cfg_eff[6:0] = main_cfg_q;
	assign cfg_eff[13:7] = rdr_locked ? `PRESET_DECODE : rdr_cfg_q;
	assign port_en      = {fit_s2_q, 1'b1};
	assign rx_in        = {rdr_rxd, main_rxd};
	assign main_txd     = txd[0];
	assign rdr_txd      = txd[1];

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : port
			wire [6:0]  cfg = cfg_eff[g*`CFG_W +: `CFG_W];
			wire        nd8 = cfg[1];
			wire        two = cfg[0];
			// eight data with two stop never carries parity
			wire [1:0]  pm  = (cfg[`F_FRAME] == `FR_8_2) ? `PAR_NONE : cfg[`F_PAR];
			wire        np  = (pm == `PAR_EVEN) || (pm == `PAR_ODD);
			wire [3:0]  nd  = `DATA7 + {3'h0, nd8};
			wire [3:0]  len = `LEN_BASE + {3'h0, nd8} + {3'h0, np} + {3'h0, two};
			reg  [16:0] div;
			reg  [11:0] frame;
			reg  [7:0]  dm;
			reg         tx_busy_q;
			reg         txd_q;
			reg  [11:0] tx_sh_q;
			reg  [3:0]  tx_cnt_q;
			reg  [3:0]  tx_len_q;
			reg  [16:0] tx_tmr_q;
			reg  [16:0] tx_div_q;
			reg         rx_s1_q;
			reg         rx_s2_q;
			reg  [1:0]  rx_st_q;
			reg  [16:0] rx_tmr_q;
			reg  [16:0] rx_div_q;
			reg  [3:0]  rx_idx_q;
			reg  [3:0]  rx_len_q;
			reg  [3:0]  rx_nd_q;
			reg         rx_np_q;
			reg  [1:0]  rx_pm_q;
			reg  [11:0] rx_sh_q;
			reg         rx_done_q;
			reg  [10:0] rx_res_q;
			reg  [7:0]  rb;
			reg         pe;
			reg         fe;
			integer     i;
			integer     j;

			// bit period per selected rate
			always @*
			begin
				case (cfg[`F_BAUD])
					`BR_2400:  div = DIV_2400;
					`BR_4800:  div = DIV_4800;
					`BR_9600:  div = DIV_9600;
					`BR_19200: div = DIV_19200;
					`BR_57600: div = DIV_57600;
					default:   div = DIV_9600;
				endcase
			end

			// start low, data lsb first, parity, ones above act as stop
			always @*
			begin
				dm = nd8 ? w_data_q[7:0] : {1'b0, w_data_q[6:0]};
				frame = 12'hfff;
				frame[0] = 1'b0;
				for (i = 0; i < 8; i = i + 1)
					if (i < nd)
						frame[i+1] = dm[i];
				if (np)
					frame[nd+1] = (pm == `PAR_ODD) ? ~^dm : ^dm;
			end

			// transmitter; settings latched so a config write cannot tear a frame
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					tx_busy_q <= 1'b0;
					txd_q     <= 1'b1;
					tx_sh_q   <= 12'hfff;
					tx_cnt_q  <= 4'h0;
					tx_len_q  <= 4'h0;
					tx_tmr_q  <= 17'h00000;
					tx_div_q  <= 17'h00000;
				end
				else if (!tx_busy_q)
				begin
					txd_q <= 1'b1;
					if (tx_go[g] && port_en[g])
					begin
						txd_q     <= frame[0];
						tx_sh_q   <= {1'b1, frame[11:1]};
						tx_cnt_q  <= 4'h1;
						tx_len_q  <= len;
						tx_div_q  <= div;
						tx_tmr_q  <= div - 17'h00001;
						tx_busy_q <= 1'b1;
					end
				end
				else if (tx_tmr_q == 17'h00000)
				begin
					if (tx_cnt_q == tx_len_q)
					begin
						tx_busy_q <= 1'b0;
						txd_q     <= 1'b1;
					end
					else
					begin
						txd_q    <= tx_sh_q[0];
						tx_sh_q  <= {1'b1, tx_sh_q[11:1]};
						tx_cnt_q <= tx_cnt_q + 4'h1;
						tx_tmr_q <= tx_div_q - 17'h00001;
					end
				end
				else
					tx_tmr_q <= tx_tmr_q - 17'h00001;
			end

			// frame check on the collected samples
			always @*
			begin
				rb = rx_nd_q[0] ? {1'b0, rx_sh_q[7:1]} : rx_sh_q[8:1];
				pe = rx_np_q && (rx_sh_q[rx_nd_q+1] != ((rx_pm_q == `PAR_ODD) ? ~^rb : ^rb));
				fe = 1'b0;
				for (j = 1; j < 12; j = j + 1)
					if ((j > rx_nd_q + {3'h0, rx_np_q}) && (j < rx_len_q) && !rx_sh_q[j])
						fe = 1'b1;
			end

			// receiver: half period to mid start, then one sample per bit
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					rx_s1_q   <= 1'b1;
					rx_s2_q   <= 1'b1;
					rx_st_q   <= RX_IDLE;
					rx_tmr_q  <= 17'h00000;
					rx_div_q  <= 17'h00000;
					rx_idx_q  <= 4'h0;
					rx_len_q  <= 4'h0;
					rx_nd_q   <= 4'h0;
					rx_np_q   <= 1'b0;
					rx_pm_q   <= `PAR_NONE;
					rx_sh_q   <= 12'h000;
					rx_done_q <= 1'b0;
					rx_res_q  <= 11'h000;
				end
				else
				begin
					rx_s1_q   <= rx_in[g];
					rx_s2_q   <= rx_s1_q;
					rx_done_q <= 1'b0;
					case (rx_st_q)
						RX_IDLE:
							if (port_en[g] && !rx_s2_q)
							begin
								rx_st_q  <= RX_START;
								rx_tmr_q <= {1'b0, div[16:1]};
								rx_div_q <= div;
								rx_len_q <= len;
								rx_nd_q  <= nd;
								rx_np_q  <= np;
								rx_pm_q  <= pm;
							end
						RX_START:
							if (rx_tmr_q != 17'h00000)
								rx_tmr_q <= rx_tmr_q - 17'h00001;
							else if (rx_s2_q)
								rx_st_q <= RX_IDLE; // glitch, not a start bit
							else
							begin
								rx_st_q  <= RX_DATA;
								rx_idx_q <= 4'h1;
								rx_tmr_q <= rx_div_q - 17'h00001;
							end
						RX_DATA:
							if (rx_tmr_q != 17'h00000)
								rx_tmr_q <= rx_tmr_q - 17'h00001;
							else
							begin
								rx_sh_q[rx_idx_q] <= rx_s2_q;
								rx_idx_q <= rx_idx_q + 4'h1;
								rx_tmr_q <= rx_div_q - 17'h00001;
								if (rx_idx_q == rx_len_q - 4'h1)
									rx_st_q <= RX_DONE;
							end
						RX_DONE:
						begin
							rx_res_q  <= {fe, pe, 1'b0, rb};
							rx_done_q <= 1'b1;
							rx_st_q   <= RX_IDLE;
						end
						default:
							rx_st_q <= RX_IDLE;
					endcase
				end
			end

			assign txd[g]            = txd_q;
			assign tx_busy[g]        = tx_busy_q;
			assign rx_done[g]        = rx_done_q;
			assign rx_res[g*11 +: 11] = rx_res_q;
		end
	endgenerate

	// write channel: address and data taken in either order
	assign awready  = !aw_got_q && !bvalid;
	assign wready   = !w_got_q && !bvalid;
	assign wr_fire  = aw_got_q && w_got_q && !bvalid;
	assign tx_go[0] = wr_fire && (aw_addr_q == `REG_MAIN_TX) && w_strb_q[0];
	assign tx_go[1] = wr_fire && (aw_addr_q == `REG_RDR_TX) && w_strb_q[0];
	assign new_type = w_strb_q[1] ? w_data_q[`F_TYPE] : rdr_type_q;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q   <= 1'b0;
			w_got_q    <= 1'b0;
			aw_addr_q  <= 8'h00;
			w_data_q   <= 32'h00000000;
			w_strb_q   <= 4'h0;
			bvalid     <= 1'b0;
			bresp      <= `RESP_OKAY;
			main_cfg_q <= `MAIN_CFG_RST;
			rdr_cfg_q  <= `PRESET_PLAIN;
			rdr_type_q <= `RT_PLAIN;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_got_q  <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (wr_fire)
			begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= (aw_addr_q > `REG_STATUS || aw_addr_q[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
				if (aw_addr_q == `REG_MAIN_CFG && w_strb_q[0])
					main_cfg_q <= w_data_q[`F_CFG];
				if (aw_addr_q == `REG_RDR_CFG && fit_s2_q)
				begin
					rdr_type_q <= new_type;
					if (new_type == `RT_PLAIN && rdr_type_q != `RT_PLAIN)
						rdr_cfg_q <= `PRESET_PLAIN;
					else if (w_strb_q[0] && new_type != `RT_DECODE)
						rdr_cfg_q <= w_data_q[`F_CFG];
				end
			end
		end
	end

	// read channel; reading a receive word clears its valid flag
	assign arready     = !rvalid;
	assign rd_fire     = arvalid && arready;
	assign rd_clear[0] = rd_fire && (araddr == `REG_MAIN_RX);
	assign rd_clear[1] = rd_fire && (araddr == `REG_RDR_RX);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid    <= 1'b0;
			rdata     <= 32'h00000000;
			rresp     <= `RESP_OKAY;
			rxv_q     <= 2'h0;
			rx_word_q <= 22'h000000;
		end
		else
		begin
			// a new character wins over a clear in the same cycle
			rxv_q <= rx_done | (rxv_q & ~rd_clear);
			if (rx_done[0])
				rx_word_q[10:0] <= rx_res[10:0];
			if (rx_done[1])
				rx_word_q[21:11] <= rx_res[21:11];
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (rd_fire)
			begin
				rvalid <= 1'b1;
				rresp  <= `RESP_OKAY;
				rdata  <= 32'h00000000;
				case (araddr)
					`REG_MAIN_CFG: rdata[`F_CFG] <= main_cfg_q;
					`REG_RDR_CFG:  rdata[9:0] <= {rdr_type_q, 1'b0, cfg_eff[13:7]};
					`REG_MAIN_TX:  rdata[0] <= tx_busy[0];
					`REG_RDR_TX:   rdata[0] <= tx_busy[1];
					`REG_MAIN_RX:  rdata[10:0] <= {rx_word_q[10:9], rxv_q[0], rx_word_q[7:0]};
					`REG_RDR_RX:   rdata[10:0] <= {rx_word_q[21:20], rxv_q[1], rx_word_q[18:11]};
					`REG_STATUS:   rdata[4:0] <= {rxv_q, fit_s2_q, tx_busy};
					default:       rresp <= `RESP_SLVERR;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ===== verilog/configurable_serial_framing_consts.vh
// Function
// - seven or eight data, one or two stop
// - eight data two stop forces no parity
// - none, even or odd parity both directions
// - plain scanner preset seven two none 9600
// - decoding scanner preset seven one odd 9600
// - decoding scanner locks reader port framing
// - reader unfitted makes reader settings inert
`ifndef CONFIGURABLE_SERIAL_FRAMING_CONSTS_VH
`define CONFIGURABLE_SERIAL_FRAMING_CONSTS_VH

// register byte offsets
`define REG_MAIN_CFG    8'h00
`define REG_RDR_CFG     8'h04
`define REG_MAIN_TX     8'h08
`define REG_RDR_TX      8'h0c
`define REG_MAIN_RX     8'h10
`define REG_RDR_RX      8'h14
`define REG_STATUS      8'h18

// configuration fields
`define F_FRAME         1:0
`define F_PAR           3:2
`define F_BAUD          6:4
`define F_CFG           6:0
`define F_TYPE          9:8
`define CFG_W           7

// frame codes: bit 1 = eight data, bit 0 = two stop
`define FR_8_2          2'h3
`define PAR_NONE        2'h0
`define PAR_EVEN        2'h1
`define PAR_ODD         2'h2
`define BR_2400         3'h0
`define BR_4800         3'h1
`define BR_9600         3'h2
`define BR_19200        3'h3
`define BR_57600        3'h4

// reader types
`define RT_PLAIN        2'h0
`define RT_DECODE       2'h1

// reset and preset values
`define MAIN_CFG_RST    7'h22
`define PRESET_PLAIN    7'h21
`define PRESET_DECODE   7'h28

// receive word fields
`define RX_VALID        8
`define RX_PERR         9
`define RX_FERR         10

// frame length: start + seven data + one stop
`define LEN_BASE        4'h9
`define DATA7           4'h7

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// rates in baud, clock in hertz
`define CLK_HZ_DEF      200000000
`define BAUD_2400       2400
`define BAUD_4800       4800
`define BAUD_9600       9600
`define BAUD_19200      19200
`define BAUD_57600      57600
`define CNT_W           17

`endif
